// ==== thermal_throttle_params.svh ====
/*
  Holds the register map, field positions, reset values and timing counts
  of the thermal throttle controller as macros.
  Assumes a 125 MHz core clock and APB byte addressing with 32-bit words.
*/
`ifndef THERMAL_THROTTLE_PARAMS_SVH
`define THERMAL_THROTTLE_PARAMS_SVH

// Register byte offsets
`define TT_ADDR_MODE_CTRL 8'h00
`define TT_ADDR_ON_DEMAND 8'h04
`define TT_ADDR_OP_REQUEST 8'h08
`define TT_ADDR_OP_THROTTLE 8'h0C
`define TT_ADDR_STATUS 8'h10

// Mode control fields
`define TT_CTRL_AUTO_BIT 0
`define TT_CTRL_CLK_MOD_BIT 1
`define TT_CTRL_OP_POINT_BIT 2
`define TT_CTRL_IRQ_RISE_BIT 3
`define TT_CTRL_IRQ_FALL_BIT 4
`define TT_CTRL_RESET 5'h00

// On-demand control fields
`define TT_OD_ENABLE_BIT 4
`define TT_OD_DUTY_LSB 1
`define TT_OD_DUTY_MSB 3
`define TT_OD_RESET 5'h00

// Operating points: larger code means higher frequency
`define TT_OP_WIDTH 8
`define TT_OP_REQUEST_RESET 8'hFF
`define TT_OP_THROTTLE_RESET 8'h40

// Status fields
`define TT_ST_TCC_BIT 0
`define TT_ST_DIE_HOT_BIT 1
`define TT_ST_TRIP_BIT 2
`define TT_ST_FORCED_BIT 3
`define TT_ST_DEFERRED_BIT 4
`define TT_ST_CLK_MOD_BIT 5
`define TT_ST_OP_LSB 8

// Duty codes in eighths of the modulation period
`define TT_DUTY_AUTO 3'h4
`define TT_DUTY_ZERO 3'h0

// Timing
`define TT_CLK_PERIOD_NS 8
`define TT_SETTLE_NS 2000
`define TT_SETTLE_CYCLES ((`TT_SETTLE_NS + `TT_CLK_PERIOD_NS - 1) / `TT_CLK_PERIOD_NS)
`define TT_MOD_STEP_NS 1000
`define TT_MOD_STEP_CYCLES ((`TT_MOD_STEP_NS + `TT_CLK_PERIOD_NS - 1) / `TT_CLK_PERIOD_NS)

`endif

// ==== thermal_throttle_pkg.sv ====
/*
  Types shared by the thermal throttle controller files.
  Uses none of the macros of thermal_throttle_params.svh; the state type is a fixed four bits.
*/
package thermal_throttle_pkg;

  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_settle = 4'b0010,
    st_op_throttle = 4'b0100,
    st_modulate = 4'b1000
  } auto_state_type;

endpackage : thermal_throttle_pkg

// ==== clock_duty_modulator.sv ====
/*
  Core clock gate generator: splits a modulation period into eight steps
  and keeps the core clock enabled for duty steps out of eight.
  Assumes run and duty come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "thermal_throttle_params.svh"

module clock_duty_modulator #(
  parameter int STEP_CYCLES = `TT_MOD_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic [2:0] duty,
  // Gate
  output logic clock_on
);

  logic [15:0] step_count;
  logic [2:0] phase;
  wire step_done = (step_count == 16'(STEP_CYCLES - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_count <= 16'h0000;
      phase <= 3'h0;
    end else if (!run || step_done) begin
      step_count <= 16'h0000;
      phase <= run ? phase + 3'h1 : 3'h0;
    end else begin
      step_count <= step_count + 16'h0001;
    end
  end

  // Registered so the gate never glitches at a duty change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_on <= 1'b1;
    end else begin
      clock_on <= !run || (phase < duty);
    end
  end

endmodule : clock_duty_modulator

// ==== thermal_throttle_control.sv ====
/*
  Thermal throttle controller: activates the thermal control circuit on
  over-temperature, on software demand or on the forced throttle pin, and
  drives core clock gating, operating point, die-hot and catastrophic trip.
  Assumes sensor flags are already on this clock, an APB master on the
  register port, and core logic that honours core_clock_on and op_point.
*/
// Behaviour
// RL1 - Thermal control starts at the fixed maximum junction temperature, never configurable.
// RL2 - While throttled, snooping continues and interrupts are latched until clocks run.
// RL3 - Automatic and on-demand modes exist; automatic wins while hot.
// RL4 - Automatic mode activates only at the maximum operating temperature.
// RL5 - Operating-point throttle comes first; clock modulation added if still too hot.
// RL6 - Hot lowers the operating point; cooling restores the last requested point.
// RL7 - A higher request during operating-point throttle waits until the event ends.
// RL8 - A lower request during operating-point throttle takes effect immediately.
// RL9 - Automatic clock modulation runs at a fixed half-on, half-off duty.
// RL10 - Cooling ends modulation and thermal control, with hysteresis near the trip.
// RL11 - Setting the on-demand enable bit starts thermal control at once.
// RL12 - On-demand duty follows a three-bit field, 12.5 to 87.5 percent.
// RL13 - Die-hot output goes low while the die is above the trip point.
// RL14 - Die-hot assertion and deassertion can each raise an interrupt event.
// RL15 - Die-hot is not newly asserted in a low-power state.
// RL16 - Die-hot asserted on low-power entry holds until exit and cooling.
// RL17 - Catastrophic temperature shuts the core down and asserts the trip output.
// RL18 - Catastrophic trip ignores processor activity and makes no bus cycles.
// RL19 - The platform removes core supply within its time limit after trip.
// RL20 - Firmware must enable automatic throttling for in-spec operation.
// RL21 - With throttling enabled, the forced-throttle pin holds thermal control active.
// RL22 - The forced-throttle pin alone never asserts die-hot.
// RL23 - Sensor flags arrive synchronised; the forced-throttle pin is synchronised here.
`timescale 1ns/1ps
`include "thermal_throttle_params.svh"

module thermal_throttle_control #(
  parameter int SETTLE_CYCLES = `TT_SETTLE_CYCLES,
  parameter int MOD_STEP_CYCLES = `TT_MOD_STEP_CYCLES,
  parameter int OP_WIDTH = `TT_OP_WIDTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Thermal sensor flags
  input wire logic over_temp,
  input wire logic below_critical,
  input wire logic catastrophic_temp,
  // Platform pins
  input wire logic forced_throttle_in_n,
  output logic die_hot_out_n,
  output logic catastrophic_trip_out_n,
  // Core power state
  input wire logic low_power_state,
  // Core control
  output logic core_clock_on,
  output logic [OP_WIDTH-1:0] op_point,
  output logic core_shutdown,
  // Interrupt path
  input wire logic irq_request,
  output logic irq_deliver,
  output logic die_hot_event
);

  // Software state
  logic [4:0] mode_ctrl;
  logic [4:0] on_demand;
  logic [OP_WIDTH-1:0] op_request;
  logic [OP_WIDTH-1:0] op_throttle;

  // Thermal state
  thermal_throttle_pkg::auto_state_type state;
  thermal_throttle_pkg::auto_state_type next_state;
  logic hot;
  logic die_hot;
  logic trip;
  logic irq_pending;
  logic [15:0] settle_count;
  logic forced_meta;
  logic forced_sync;

  // APB decode
  wire apb_setup = psel && !penable;
  wire apb_write = psel && penable && pwrite;
  wire sel_ctrl = (paddr == `TT_ADDR_MODE_CTRL);
  wire sel_od = (paddr == `TT_ADDR_ON_DEMAND);
  wire sel_req = (paddr == `TT_ADDR_OP_REQUEST);
  wire sel_thr = (paddr == `TT_ADDR_OP_THROTTLE);
  wire sel_st = (paddr == `TT_ADDR_STATUS);
  wire mapped = sel_ctrl || sel_od || sel_req || sel_thr || sel_st;

  // Mode decode
  wire auto_en = mode_ctrl[`TT_CTRL_AUTO_BIT];
  wire clk_mod_en = mode_ctrl[`TT_CTRL_CLK_MOD_BIT];
  wire op_thr_en = mode_ctrl[`TT_CTRL_OP_POINT_BIT];
  wire irq_rise_en = mode_ctrl[`TT_CTRL_IRQ_RISE_BIT];
  wire irq_fall_en = mode_ctrl[`TT_CTRL_IRQ_FALL_BIT];
  wire od_en = on_demand[`TT_OD_ENABLE_BIT];
  wire [2:0] od_duty = on_demand[`TT_OD_DUTY_MSB:`TT_OD_DUTY_LSB];
  wire auto_active = (state != thermal_throttle_pkg::st_idle);
  wire op_throttling = auto_active && op_thr_en;
  wire auto_modulating = (state == thermal_throttle_pkg::st_modulate);
  wire forced_active = auto_en && forced_sync;
  wire settle_done = (settle_count == 16'(SETTLE_CYCLES - 1));

  // Forced throttle pin: two flops before any use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      forced_meta <= 1'b0;
      forced_sync <= 1'b0;
    end else begin
      forced_meta <= !forced_throttle_in_n; // RL23
      forced_sync <= forced_meta;
    end
  end

  // Hysteresis: set at the trip, clear only once the sensor reads below critical
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hot <= 1'b0;
    end else if (over_temp) begin
      hot <= 1'b1; // RL1
    end else if (below_critical) begin
      hot <= 1'b0; // RL10
    end
  end

  // Automatic mode sequence
  always_comb begin
    next_state = state;
    case (state)
      thermal_throttle_pkg::st_idle: begin
        if (auto_en && over_temp && op_thr_en) begin
          next_state = thermal_throttle_pkg::st_settle; // RL4 RL5
        end else if (auto_en && over_temp && clk_mod_en) begin
          next_state = thermal_throttle_pkg::st_modulate; // RL4
        end
      end
      thermal_throttle_pkg::st_settle: begin
        if (!hot || !auto_en) begin
          next_state = thermal_throttle_pkg::st_idle; // RL10
        end else if (settle_done && over_temp && clk_mod_en) begin
          next_state = thermal_throttle_pkg::st_modulate; // RL5
        end else if (settle_done) begin
          next_state = thermal_throttle_pkg::st_op_throttle;
        end
      end
      thermal_throttle_pkg::st_op_throttle: begin
        if (!hot || !auto_en) begin
          next_state = thermal_throttle_pkg::st_idle; // RL10
        end else if (over_temp && clk_mod_en) begin
          next_state = thermal_throttle_pkg::st_modulate; // RL5
        end
      end
      thermal_throttle_pkg::st_modulate: begin
        if (!hot || !auto_en) begin
          next_state = thermal_throttle_pkg::st_idle; // RL10
        end
      end
      default: begin
        next_state = thermal_throttle_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= thermal_throttle_pkg::st_idle;
    end else begin
      state <= next_state;
    end
  end

  // The new operating point needs time to cool the die before adding modulation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_count <= 16'h0000;
    end else if (state == thermal_throttle_pkg::st_settle && !settle_done) begin
      settle_count <= settle_count + 16'h0001;
    end else if (state != thermal_throttle_pkg::st_settle) begin
      settle_count <= 16'h0000;
    end
  end

  // Clock modulation source: automatic first, then software demand, then the pin
  wire mod_run = auto_modulating || (!op_throttling && (od_en || forced_active));
  wire [2:0] od_duty_used = (od_duty == `TT_DUTY_ZERO) ? `TT_DUTY_AUTO : od_duty;
  wire [2:0] mod_duty = (auto_modulating || !od_en) ? `TT_DUTY_AUTO : od_duty_used; // RL3 RL9 RL12
  wire tcc_active = auto_active || od_en || forced_active; // RL11 RL21

  clock_duty_modulator #(
    .STEP_CYCLES(MOD_STEP_CYCLES)
  ) u_modulator (
    .clk(clk),
    .rst(rst),
    .run(mod_run && !trip && !catastrophic_temp), // RL17
    .duty(mod_duty),
    .clock_on(core_clock_on)
  );

  // Operating point: a lower software request wins, a higher one waits for the event end
  wire req_below = (op_request < op_throttle);
  wire op_deferred = op_throttling && !req_below;
  wire [OP_WIDTH-1:0] next_op_point = op_deferred ? op_throttle : op_request; // RL6 RL7 RL8

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_point <= `TT_OP_REQUEST_RESET;
    end else begin
      op_point <= next_op_point; // RL6
    end
  end

  // Die-hot: low-power entry may keep it, never start it; the pin plays no part
  wire next_die_hot = low_power_state ? die_hot : over_temp; // RL13 RL15 RL16 RL22

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      die_hot <= 1'b0;
      die_hot_out_n <= 1'b1;
      die_hot_event <= 1'b0;
    end else begin
      die_hot <= next_die_hot;
      die_hot_out_n <= !next_die_hot; // RL13
      die_hot_event <= (next_die_hot && !die_hot && irq_rise_en)
        || (!next_die_hot && die_hot && irq_fall_en); // RL14
    end
  end

  // Catastrophic trip: latched until reset, works on the raw flag alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trip <= 1'b0;
      catastrophic_trip_out_n <= 1'b1;
      core_shutdown <= 1'b0;
    end else if (catastrophic_temp || trip) begin
      trip <= 1'b1; // RL17 RL18
      catastrophic_trip_out_n <= 1'b0; // RL17
      core_shutdown <= 1'b1; // RL17
    end
  end

  // Interrupts are held while clocks are gated off; a new request beats delivery
  // Snooping is never gated by this block, so it runs on through throttling
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_pending <= 1'b0;
      irq_deliver <= 1'b0;
    end else begin
      irq_deliver <= irq_pending && core_clock_on && !trip; // RL2
      if (irq_request) begin
        irq_pending <= 1'b1; // RL2
      end else if (core_clock_on && !trip) begin
        irq_pending <= 1'b0;
      end
    end
  end

  // Software registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_ctrl <= `TT_CTRL_RESET; // RL20
      on_demand <= `TT_OD_RESET;
      op_request <= `TT_OP_REQUEST_RESET;
      op_throttle <= `TT_OP_THROTTLE_RESET;
    end else if (apb_write) begin
      if (sel_ctrl) begin
        mode_ctrl <= pwdata[4:0];
      end else if (sel_od) begin
        on_demand <= pwdata[4:0]; // RL11 RL12
      end else if (sel_req) begin
        op_request <= pwdata[OP_WIDTH-1:0]; // RL7 RL8
      end else if (sel_thr) begin
        op_throttle <= pwdata[OP_WIDTH-1:0];
      end
    end
  end

  // Status word
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h00000000;
    status_word[`TT_ST_TCC_BIT] = tcc_active;
    status_word[`TT_ST_DIE_HOT_BIT] = die_hot;
    status_word[`TT_ST_TRIP_BIT] = trip;
    status_word[`TT_ST_FORCED_BIT] = forced_sync;
    status_word[`TT_ST_DEFERRED_BIT] = op_deferred;
    status_word[`TT_ST_CLK_MOD_BIT] = mod_run;
    status_word[`TT_ST_OP_LSB +: OP_WIDTH] = op_point;
  end

  // Read data captured in the setup phase, so it is steady through the access phase
  wire [31:0] read_mux = sel_ctrl ? {27'h0000000, mode_ctrl}
    : sel_od ? {27'h0000000, on_demand}
    : sel_req ? {{(32 - OP_WIDTH){1'b0}}, op_request}
    : sel_thr ? {{(32 - OP_WIDTH){1'b0}}, op_throttle}
    : sel_st ? status_word
    : 32'h00000000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (apb_setup && !pwrite) begin
      prdata <= read_mux;
    end
  end

  // One wait-free access phase; unmapped addresses answer with an error
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;

endmodule : thermal_throttle_control

// ==== thermal_throttle_checker.sv ====
/*
  Port checker for thermal_throttle_control, bound to every instance.
  Assumes one clock domain with rst active high.
*/
`timescale 1ns/1ps

module thermal_throttle_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Sensor and power state
  input wire logic over_temp,
  input wire logic catastrophic_temp,
  input wire logic low_power_state,
  // Outputs watched
  input wire logic die_hot_out_n,
  input wire logic catastrophic_trip_out_n,
  input wire logic core_clock_on,
  input wire logic core_shutdown,
  input wire logic die_hot_event
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  bus_ready_a: assert property (pready == (psel && penable))
    else $error("pready not in access phase");
  bus_error_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  hot_assert_a: assert property (over_temp && !low_power_state |=> !die_hot_out_n)
    else $error("die hot not asserted");
  hot_cause_a: assert property ($fell(die_hot_out_n) |-> $past(over_temp))
    else $error("die hot without over temperature");
  sleep_new_a: assert property ($fell(die_hot_out_n) |-> !$past(low_power_state))
    else $error("die hot raised in low power");
  sleep_hold_a: assert property (low_power_state && !die_hot_out_n |=> !die_hot_out_n)
    else $error("die hot dropped in low power");
  cool_cause_a: assert property ($rose(die_hot_out_n) |-> !$past(over_temp))
    else $error("die hot released while hot");
  trip_set_a: assert property (catastrophic_temp |=> !catastrophic_trip_out_n && core_shutdown)
    else $error("trip not taken");
  trip_stick_a: assert property (!catastrophic_trip_out_n |=> !catastrophic_trip_out_n)
    else $error("trip released");
  trip_quiet_a: assert property (core_shutdown |-> core_clock_on)
    else $error("modulation during shutdown");
  event_edge_a: assert property (die_hot_event |->
    (die_hot_out_n != $past(die_hot_out_n)) || ($past(die_hot_out_n) != $past(die_hot_out_n, 2)))
    else $error("event without die hot edge");
endmodule : thermal_throttle_checker

bind thermal_throttle_control thermal_throttle_checker checker_i (
  .clk, .rst, .psel, .penable, .pready, .pslverr, .over_temp, .catastrophic_temp,
  .low_power_state, .die_hot_out_n, .catastrophic_trip_out_n, .core_clock_on,
  .core_shutdown, .die_hot_event);

// ==== platform_model.sv ====
/*
  Platform side: forced throttle pin and core supply removal after a trip.
  Assumes bench commands on clk.
*/
`timescale 1ns/1ps

module platform_model #(
  parameter int SUPPLY_OFF_CYCLES = 3
) (
  // Clock
  input wire logic clk,
  // Bench command
  input wire logic force_req,
  // Device pins
  input wire logic catastrophic_trip_out_n,
  output logic forced_throttle_in_n,
  output logic core_supply_on
);
  int off_count = 0;

  initial forced_throttle_in_n = 1'b1;
  initial core_supply_on = 1'b1;
  // Held low for as long as the platform wants throttling
  always @(posedge clk) forced_throttle_in_n <= !force_req;
  // Fixed short delay, well inside any platform limit
  always @(posedge clk) begin
    if (!catastrophic_trip_out_n && off_count < SUPPLY_OFF_CYCLES) off_count <= off_count + 1;
    core_supply_on <= off_count != SUPPLY_OFF_CYCLES;
  end
endmodule : platform_model

// ==== thermal_throttle_control_bench.sv ====
/*
  Self-checking bench for thermal_throttle_control.
  Assumes platform_model beside the design and the bound checker.
*/
`timescale 1ns/1ps
`include "thermal_throttle_params.svh"

module thermal_throttle_control_bench;
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, op_point;
  logic [31:0] pwdata, prdata, c;
  logic over_temp, below_critical, catastrophic_temp, forced_throttle_in_n;
  logic die_hot_out_n, catastrophic_trip_out_n, low_power_state, core_clock_on;
  logic core_shutdown, irq_request, irq_deliver, die_hot_event, force_req, core_supply_on;
  int failures = 0;
  int num_checks = 0;
  int events = 0;
  int delivered = 0;

  // Short counts keep modulation periods at 16 cycles
  thermal_throttle_control #(.SETTLE_CYCLES(4), .MOD_STEP_CYCLES(2)) DUT (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .over_temp, .below_critical, .catastrophic_temp, .forced_throttle_in_n,
    .die_hot_out_n, .catastrophic_trip_out_n, .low_power_state, .core_clock_on,
    .op_point, .core_shutdown, .irq_request, .irq_deliver, .die_hot_event);
  platform_model platform (.clk, .force_req, .catastrophic_trip_out_n,
    .forced_throttle_in_n, .core_supply_on);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (die_hot_event === 1'b1) events <= events + 1;
    if (irq_deliver === 1'b1) delivered <= delivered + 1;
  end

  task automatic results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(n, q, x);
    check(n, 32'(e), 32'(xe));
  endtask : rd

  task automatic count_on(input int n);
    c = 32'h0;
    repeat (n) begin
      @(posedge clk);
      c = c + 32'(core_clock_on === 1'b1);
    end
  endtask : count_on

  task automatic heat(input logic h);
    over_temp <= h;
    below_critical <= !h;
    tick(6);
  endtask : heat

  task automatic regs;
    rd("mode", `TT_ADDR_MODE_CTRL, 32'h0, 1'b0);
    rd("demand", `TT_ADDR_ON_DEMAND, 32'h0, 1'b0);
    rd("request", `TT_ADDR_OP_REQUEST, 32'hFF, 1'b0);
    rd("target", `TT_ADDR_OP_THROTTLE, 32'h40, 1'b0);
    wr(`TT_ADDR_STATUS, 32'hFFFFFFFF);
    rd("status", `TT_ADDR_STATUS, 32'hFF00, 1'b0);
    wr(8'h20, 32'hFFFFFFFF);
    rd("unmapped", 8'h20, 32'h0, 1'b1);
  endtask : regs

  task automatic auto_mode;
    wr(`TT_ADDR_MODE_CTRL, 32'h5);
    heat(1'b1);
    check("op", 32'(op_point), 32'h40);
    count_on(32);
    check("op only", c, 32'd32);
    wr(`TT_ADDR_MODE_CTRL, 32'h7);
    tick(8);
    count_on(32);
    check("auto duty", c, 32'd16);
    wr(`TT_ADDR_OP_REQUEST, 32'h20);
    tick(2);
    check("lower req", 32'(op_point), 32'h20);
    wr(`TT_ADDR_OP_REQUEST, 32'h80);
    tick(2);
    check("higher req", 32'(op_point), 32'h40);
    over_temp <= 1'b0;
    tick(6);
    check("hysteresis", 32'(op_point), 32'h40);
    heat(1'b0);
    check("restored", 32'(op_point), 32'h80);
    count_on(32);
    check("mod off", c, 32'd32);
  endtask : auto_mode

  task automatic on_demand;
    wr(`TT_ADDR_MODE_CTRL, 32'h0);
    for (int d = 1; d < 8; d++) begin
      wr(`TT_ADDR_ON_DEMAND, 32'h10 | 32'(d << 1));
      tick(16);
      count_on(32);
      check("demand duty", c, 32'(d * 4));
    end
    check("no hot", 32'(die_hot_out_n), 32'h1);
    wr(`TT_ADDR_MODE_CTRL, 32'h5);
    wr(`TT_ADDR_ON_DEMAND, 32'h12);
    heat(1'b1);
    count_on(32);
    check("auto wins", c, 32'd32);
    heat(1'b0);
    wr(`TT_ADDR_ON_DEMAND, 32'h0);
  endtask : on_demand

  task automatic forced;
    wr(`TT_ADDR_MODE_CTRL, 32'h0);
    force_req <= 1'b1;
    tick(6);
    count_on(32);
    check("forced off", c, 32'd32);
    wr(`TT_ADDR_MODE_CTRL, 32'h1);
    tick(6);
    count_on(32);
    check("forced duty", c, 32'd16);
    check("forced cool", 32'(die_hot_out_n), 32'h1);
    force_req <= 1'b0;
    tick(6);
    count_on(32);
    check("forced end", c, 32'd32);
  endtask : forced

  task automatic low_power;
    low_power_state <= 1'b1;
    heat(1'b1);
    check("sleep new", 32'(die_hot_out_n), 32'h1);
    low_power_state <= 1'b0;
    tick(3);
    check("wake hot", 32'(die_hot_out_n), 32'h0);
    low_power_state <= 1'b1;
    heat(1'b0);
    check("sleep hold", 32'(die_hot_out_n), 32'h0);
    low_power_state <= 1'b0;
    tick(3);
    check("wake cool", 32'(die_hot_out_n), 32'h1);
  endtask : low_power

  task automatic irq;
    logic [31:0] e0;
    for (int i = 0; i < 2; i++) begin
      wr(`TT_ADDR_MODE_CTRL, i ? 32'h11 : 32'h9);
      e0 = 32'(events);
      heat(1'b1);
      check("rise event", 32'(events) - e0, 32'(1 - i));
      heat(1'b0);
      check("fall event", 32'(events) - e0, 32'h1);
    end
    wr(`TT_ADDR_ON_DEMAND, 32'h12);
    e0 = 32'(delivered);
    irq_request <= 1'b1;
    tick(1);
    irq_request <= 1'b0;
    tick(40);
    check("irq served", 32'(32'(delivered) != e0), 32'h1);
    wr(`TT_ADDR_ON_DEMAND, 32'h0);
  endtask : irq

  task automatic trip;
    catastrophic_temp <= 1'b1;
    tick(1);
    catastrophic_temp <= 1'b0;
    tick(8);
    check("trip pin", 32'(catastrophic_trip_out_n), 32'h0);
    check("shutdown", 32'(core_shutdown), 32'h1);
    check("clock held", 32'(core_clock_on), 32'h1);
    check("supply", 32'(core_supply_on), 32'h0);
  endtask : trip

  // Whole run is about 800 cycles; this allows several times that
  initial begin
    #100000;
    failures++;
    results();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    over_temp = 1'b0;
    below_critical = 1'b1;
    catastrophic_temp = 1'b0;
    low_power_state = 1'b0;
    irq_request = 1'b0;
    force_req = 1'b0;
    tick(8);
    rst <= 1'b0;
    tick(1);
    regs();
    auto_mode();
    on_demand();
    forced();
    low_power();
    irq();
    trip();
    results();
  end
endmodule : thermal_throttle_control_bench
